/* trig_addr_pkg.sv */
// constants for the flag, trigger and terminal address input block
package trig_addr_pkg;
  localparam int ADDR_W     = 5;
  localparam int SW_ADDR_W  = 6;
  localparam int SW_PAR_BIT = 5;
  localparam int CFG1_W     = 16;
  localparam int CFG1_SSF   = 8;
  localparam int CFG1_EXTST = 7;
  localparam int CFG6_W     = 16;
  localparam int CFG6_SRC   = 5;
  localparam logic [1:0] MODE_BC = 2'h0;
  localparam logic [1:0] MODE_RT = 2'h1;
  localparam logic [1:0] MODE_MT = 2'h2;
  localparam logic [1:0] MODE_RM = 2'h3;
  // rest levels of the flag/trigger and latch pins, loaded into their synchronisers at reset
  localparam logic FLAG_IDLE  = 1'h1;
  localparam logic LATCH_IDLE = 1'h0;
endpackage

/* edge_sync.sv */
// two-stage synchroniser with rising edge pulse
`timescale 1ns/1ps
module edge_sync #(
  // level the pin rests at, so leaving reset never fakes an edge
  parameter logic IDLE = 1'h0
) (
  // clock and reset
  input  wire logic MCLK,
  input  wire logic RST_N,
  // async level in, synced level and edge out
  input  wire logic async_in,
  output logic      sync_out,
  output logic      rise_out
);
  logic s1_r, s2_r, s3_r;
  logic s1_nxt, s2_nxt, s3_nxt;

  always_comb begin
    s1_nxt = async_in;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      s1_r <= IDLE;
      s2_r <= IDLE;
      s3_r <= IDLE;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  assign sync_out = s2_r;
  assign rise_out = s2_r & ~s3_r;
endmodule

/* trig_addr_in.sv */
// dual-purpose flag/trigger pin and terminal address source logic
`timescale 1ns/1ps
module trig_addr_in (
  // clock and reset
  input  wire logic                                MCLK,
  input  wire logic                                RST_N,
  // operating mode and configuration
  input  wire logic [1:0]                          OP_MODE,
  input  wire logic                                ENHANCED_BC,
  input  wire logic [trig_addr_pkg::CFG1_W-1:0]    CFG1_REG,
  input  wire logic [trig_addr_pkg::CFG6_W-1:0]    CFG6_REG,
  // software address load
  input  wire logic [trig_addr_pkg::SW_ADDR_W-1:0] SW_ADDR_DATA,
  input  wire logic                                SW_ADDR_LOAD,
  // controller sequencer handshake
  input  wire logic                                WAIT_TRIGGER_INSTRUCTION,
  // pins
  input  wire logic                                SUBSYSTEM_FLAG_IN_N,
  input  wire logic [trig_addr_pkg::ADDR_W-1:0]    TERMINAL_ADDRESS_PINS,
  input  wire logic                                TERMINAL_ADDRESS_PARITY_PIN,
  input  wire logic                                ADDRESS_LATCH_CONTROL,
  // outputs
  output logic                                     STATUS_SSF,
  output logic                                     SW_SSF_READ,
  output logic                                     BC_START,
  output logic                                     WAIT_ADVANCE,
  output logic [trig_addr_pkg::ADDR_W-1:0]         RT_ADDRESS,
  output logic                                     RT_PARITY,
  output logic                                     RT_ADDR_VALID
);
  logic flag_s, trig_rise;
  logic lat_s, lat_q_r, lat_q_nxt;
  logic [trig_addr_pkg::ADDR_W-1:0] ad_s1_r, ad_s2_r;
  logic par_s1_r, par_s2_r;
  logic [trig_addr_pkg::ADDR_W-1:0] held_ad_r, held_ad_nxt;
  logic held_par_r, held_par_nxt, held_r, held_nxt;
  logic [trig_addr_pkg::ADDR_W-1:0] sw_ad_r, sw_ad_nxt;
  logic sw_par_r, sw_par_nxt;
  logic ssf_nxt, swssf_nxt, start_nxt, adv_nxt, par_nxt, valid_nxt;
  logic [trig_addr_pkg::ADDR_W-1:0] ad_nxt;
  logic is_rt, is_mt, src_sw;

  // flag/trigger pin shares one synchroniser
  edge_sync #(
    .IDLE (trig_addr_pkg::FLAG_IDLE)
  ) u_trig (
    .MCLK     (MCLK),
    .RST_N    (RST_N),
    .async_in (SUBSYSTEM_FLAG_IN_N),
    .sync_out (flag_s),
    .rise_out (trig_rise)
  );

  // latch edge is found from lat_s and its delayed copy, so the pulse output stays open
  edge_sync #(
    .IDLE (trig_addr_pkg::LATCH_IDLE)
  ) u_lat (
    .MCLK     (MCLK),
    .RST_N    (RST_N),
    .async_in (ADDRESS_LATCH_CONTROL),
    .sync_out (lat_s),
    .rise_out ()
  );

  // address pins are quasi-static straps; plain two-flop sync per bit
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ad_s1_r  <= '0;
      ad_s2_r  <= '0;
      par_s1_r <= 1'h0;
      par_s2_r <= 1'h0;
    end else begin
      ad_s1_r  <= TERMINAL_ADDRESS_PINS;
      ad_s2_r  <= ad_s1_r;
      par_s1_r <= TERMINAL_ADDRESS_PARITY_PIN;
      par_s2_r <= par_s1_r;
    end
  end

  always_comb begin
    is_rt  = (OP_MODE == trig_addr_pkg::MODE_RT) || (OP_MODE == trig_addr_pkg::MODE_RM);
    is_mt  = (OP_MODE == trig_addr_pkg::MODE_MT);
    src_sw = CFG6_REG[trig_addr_pkg::CFG6_SRC];
    // status bit from pin or software bit; software bit itself untouched
    ssf_nxt   = is_rt && (!flag_s || !CFG1_REG[trig_addr_pkg::CFG1_SSF]);
    swssf_nxt = CFG1_REG[trig_addr_pkg::CFG1_SSF];
    // monitor mode fails every mode test below, so the pin is dead there
    start_nxt = (OP_MODE == trig_addr_pkg::MODE_BC) && !ENHANCED_BC && !is_mt
                && CFG1_REG[trig_addr_pkg::CFG1_EXTST] && trig_rise;
    adv_nxt   = (OP_MODE == trig_addr_pkg::MODE_BC) && ENHANCED_BC
                && WAIT_TRIGGER_INSTRUCTION && trig_rise;
    lat_q_nxt    = lat_s;
    held_ad_nxt  = held_ad_r;
    held_par_nxt = held_par_r;
    held_nxt     = held_r;
    // a low latch drops any held value: the pins pass straight through again
    if (!lat_s) begin
      held_nxt = 1'h0;
    end else if (!lat_q_r) begin
      held_ad_nxt  = ad_s2_r;
      held_par_nxt = par_s2_r;
      held_nxt     = 1'h1;
    end
    // software copy kept while pins are the source, so switching over needs no reload
    sw_ad_nxt  = sw_ad_r;
    sw_par_nxt = sw_par_r;
    if (SW_ADDR_LOAD) begin
      sw_ad_nxt  = SW_ADDR_DATA[trig_addr_pkg::ADDR_W-1:0];
      sw_par_nxt = SW_ADDR_DATA[trig_addr_pkg::SW_PAR_BIT];
    end
    // software source wins over a held latch value
    if (src_sw) begin
      ad_nxt  = sw_ad_r;
      par_nxt = sw_par_r;
    end else if (held_r) begin
      ad_nxt  = held_ad_r;
      par_nxt = held_par_r;
    end else begin
      ad_nxt  = ad_s2_r;
      par_nxt = par_s2_r;
    end
    // even ones count leaves the terminal deaf to its own non-broadcast commands
    valid_nxt = ^{ad_nxt, par_nxt};
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      lat_q_r       <= 1'h0;
      held_ad_r     <= '0;
      held_par_r    <= 1'h0;
      held_r        <= 1'h0;
      sw_ad_r       <= '0;
      sw_par_r      <= 1'h0;
      STATUS_SSF    <= 1'h0;
      SW_SSF_READ   <= 1'h0;
      BC_START      <= 1'h0;
      WAIT_ADVANCE  <= 1'h0;
      RT_ADDRESS    <= '0;
      RT_PARITY     <= 1'h0;
      RT_ADDR_VALID <= 1'h0;
    end else begin
      lat_q_r       <= lat_q_nxt;
      held_ad_r     <= held_ad_nxt;
      held_par_r    <= held_par_nxt;
      held_r        <= held_nxt;
      sw_ad_r       <= sw_ad_nxt;
      sw_par_r      <= sw_par_nxt;
      STATUS_SSF    <= ssf_nxt;
      SW_SSF_READ   <= swssf_nxt;
      BC_START      <= start_nxt;
      WAIT_ADVANCE  <= adv_nxt;
      RT_ADDRESS    <= ad_nxt;
      RT_PARITY     <= par_nxt;
      RT_ADDR_VALID <= valid_nxt;
    end
  end

  // outputs are one register behind the next-value logic, hence the |=> forms
  a_flag_status: assert property (@(posedge MCLK) disable iff (!RST_N)
    is_rt && !flag_s |=> STATUS_SSF)
    else $error("status flag not set by low pin");
  a_sw_bit_kept: assert property (@(posedge MCLK) disable iff (!RST_N)
    CFG1_REG[trig_addr_pkg::CFG1_SSF] |=> SW_SSF_READ)
    else $error("software flag bit altered");
  a_sw_bit_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    !CFG1_REG[trig_addr_pkg::CFG1_SSF] |=> !SW_SSF_READ)
    else $error("software flag bit set by pin");
  a_start_cause: assert property (@(posedge MCLK) disable iff (!RST_N)
    BC_START |-> $past(trig_rise) && !$past(ENHANCED_BC))
    else $error("start without trigger rise");
  a_start_enable: assert property (@(posedge MCLK) disable iff (!RST_N)
    BC_START |-> $past(CFG1_REG[trig_addr_pkg::CFG1_EXTST])
      && $past(OP_MODE) == trig_addr_pkg::MODE_BC)
    else $error("start without external start enable");
  a_wait_cause: assert property (@(posedge MCLK) disable iff (!RST_N)
    WAIT_ADVANCE |-> $past(WAIT_TRIGGER_INSTRUCTION) && $past(trig_rise))
    else $error("advance without trigger");
  a_monitor_quiet: assert property (@(posedge MCLK) disable iff (!RST_N)
    is_mt |=> !BC_START && !WAIT_ADVANCE && !STATUS_SSF)
    else $error("monitor mode reacted to pin");
  a_pin_source: assert property (@(posedge MCLK) disable iff (!RST_N)
    !src_sw && !held_r |=> RT_ADDRESS == $past(ad_s2_r) && RT_PARITY == $past(par_s2_r))
    else $error("pin address not used");
  a_pin_parity: assert property (@(posedge MCLK) disable iff (!RST_N)
    !src_sw && !held_r |=> RT_PARITY == $past(par_s2_r))
    else $error("pin parity not used");
  a_odd_parity: assert property (@(posedge MCLK) disable iff (!RST_N)
    RT_ADDR_VALID == ^{RT_ADDRESS, RT_PARITY})
    else $error("address valid disagrees with parity");
  a_latch_transparent: assert property (@(posedge MCLK) disable iff (!RST_N)
    !lat_s |=> !held_r)
    else $error("latch low did not return to transparent");
  a_sw_source: assert property (@(posedge MCLK) disable iff (!RST_N)
    src_sw |=> RT_ADDRESS == $past(sw_ad_r))
    else $error("software address not used");
  a_single_event: assert property (@(posedge MCLK) disable iff (!RST_N)
    trig_rise |=> !trig_rise)
    else $error("trigger event longer than one cycle");
  a_latch_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    held_r && lat_s && lat_q_r |=> held_ad_r == $past(held_ad_r))
    else $error("latched address changed");
  // the latch edge must load address and parity in the same cycle
  a_latch_capture: assert property (@(posedge MCLK) disable iff (!RST_N)
    lat_s && !lat_q_r |=> held_r && held_ad_r == $past(ad_s2_r)
      && held_par_r == $past(par_s2_r))
    else $error("latch rise did not capture pins");
  c_start: cover property (@(posedge MCLK) disable iff (!RST_N) BC_START);
  c_advance: cover property (@(posedge MCLK) disable iff (!RST_N) WAIT_ADVANCE);
  c_latched: cover property (@(posedge MCLK) disable iff (!RST_N) held_r && !src_sw);
  c_flag: cover property (@(posedge MCLK) disable iff (!RST_N) STATUS_SSF);
  c_sw_load: cover property (@(posedge MCLK) disable iff (!RST_N) SW_ADDR_LOAD && src_sw);
endmodule

/* board_pins.sv */
// board-level model driving the flag/trigger pin and the terminal address pins
`timescale 1ns/1ps
module board_pins (
  // clock
  input  wire logic                        MCLK,
  // pins driven into the block
  output logic                             flag_n,
  output logic [trig_addr_pkg::ADDR_W-1:0] addr,
  output logic                             par,
  output logic                             latch
);
  initial begin
    flag_n = 1'h1;
    addr   = 5'h00;
    par    = 1'h1;
    latch  = 1'h0;
  end
  // the low pulse and each set_addr level held three cycles so the two-flop sampler never misses a toggle
  task automatic pulse();
    @(posedge MCLK);
    flag_n <= 1'h0;
    repeat (3) @(posedge MCLK);
    flag_n <= 1'h1;
  endtask
  task automatic set_flag(input logic f);
    @(posedge MCLK);
    flag_n <= f;
  endtask
  task automatic set_addr(input logic [4:0] a, input logic p, input logic l);
    @(posedge MCLK);
    addr  <= a;
    par   <= p;
    latch <= l;
    repeat (3) @(posedge MCLK);
  endtask
endmodule

/* test_trig_addr_in.sv */
// self-checking bench for the flag, trigger and terminal address block
`timescale 1ns/1ps
module test_trig_addr_in;
  logic        MCLK = 1'h0;
  logic        RST_N = 1'h0;
  logic [1:0]  mode = 2'h0;
  logic        enh = 1'b0;
  logic [15:0] cfg1 = 16'h0100;
  logic [15:0] cfg6 = 16'h0000;
  logic [5:0]  swd = 6'h00;
  logic        swl = 1'h0;
  logic        wt = 1'h0;
  logic        flag_n, par, latch, ssf, ssf_rd, start, adv, rpar, rvld, p;
  logic [4:0]  addr, raddr, a;
  int          miscompares = 0;
  int          checks_done = 0;
  int          ns, na;
  always #50 MCLK = ~MCLK;
  board_pins i_board (.MCLK(MCLK), .flag_n(flag_n), .addr(addr), .par(par), .latch(latch));
  trig_addr_in i_dut (.MCLK(MCLK), .RST_N(RST_N), .OP_MODE(mode), .ENHANCED_BC(enh),
    .CFG1_REG(cfg1), .CFG6_REG(cfg6), .SW_ADDR_DATA(swd), .SW_ADDR_LOAD(swl),
    .WAIT_TRIGGER_INSTRUCTION(wt), .SUBSYSTEM_FLAG_IN_N(flag_n),
    .TERMINAL_ADDRESS_PINS(addr), .TERMINAL_ADDRESS_PARITY_PIN(par),
    .ADDRESS_LATCH_CONTROL(latch), .STATUS_SSF(ssf), .SW_SSF_READ(ssf_rd),
    .BC_START(start), .WAIT_ADVANCE(adv), .RT_ADDRESS(raddr), .RT_PARITY(rpar),
    .RT_ADDR_VALID(rvld));
  function automatic logic rt_like(input logic [1:0] m);
    return m == trig_addr_pkg::MODE_RT || m == trig_addr_pkg::MODE_RM;
  endfunction
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge MCLK);
    miscompares++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hDD53));
    settle(5);
    check("reset_outputs", 8'({ssf, start, adv, rvld}), 8'h00);
    @(posedge MCLK);
    RST_N <= 1'h1;
    // every mode, enhance, start-enable and wait combination; one pulse each
    for (int i = 0; i < 32; i++) begin
      @(posedge MCLK);
      mode    <= i[1:0];
      enh     <= i[2];
      cfg1[7] <= i[3];
      wt      <= i[4];
      i_board.pulse();
      ns = 0;
      na = 0;
      repeat (8) begin
        settle(1);
        ns += int'(start === 1'b1);
        na += int'(adv === 1'b1);
      end
      check("bc_start", 8'(ns), 8'(i[1:0] == 0 && !i[2] && i[3]));
      check("wait_advance", 8'(na), 8'(i[1:0] == 0 && i[2] && i[4]));
    end
    // pin level against the software flag bit (active low), in every mode
    for (int i = 0; i < 16; i++) begin
      @(posedge MCLK);
      mode    <= i[1:0];
      cfg1[8] <= !i[3];
      i_board.set_flag(i[2]);
      settle(5);
      check("status_ssf", 8'(ssf), 8'(rt_like(i[1:0]) && (!i[2] || i[3])));
      check("sw_ssf_read", 8'(ssf_rd), 8'(!i[3]));
    end
    for (int i = 0; i < 8; i++) begin
      a = 5'($urandom);
      p = 1'($urandom);
      if (i == 0) begin
        a = 5'h1F;
        p = 1'b1;
      end
      i_board.set_addr(a, p, 1'b0);
      settle(2);
      check("rt_address", 8'(raddr), 8'(a));
      check("rt_parity", 8'(rpar), 8'(p));
      check("rt_valid", 8'(rvld), 8'(^{a, p}));
      i_board.set_addr(a, p, 1'b1);
      i_board.set_addr(~a, ~p, 1'b1);
      settle(2);
      check("latched_address", 8'({rpar, raddr}), 8'({p, a}));
      @(posedge MCLK);
      cfg6[5] <= 1'b1;
      swd     <= 6'($urandom);
      swl     <= 1'b1;
      @(posedge MCLK);
      swl <= 1'b0;
      settle(4);
      check("sw_address", 8'({rpar, raddr}), 8'(swd));
      check("sw_valid", 8'(rvld), 8'(^swd));
      @(posedge MCLK);
      cfg6[5] <= 1'b0;
    end
    print_verdict();
  end
endmodule
